// ==== rtl/sece_engine.sv ====
// Two-wire serial EEPROM command engine: page write, ID page, lock, reads, serial number
// Notes on behaviour
// - Acknowledge every page write data byte except to the ID page or serial area once locked
// - Data bytes increment only low address nibble
// - Page write wraps within same page
// - Address not acknowledged during write cycle
// - Locked ID page: data not acknowledged, unchanged
// - Lock command makes ID page read-only
// - Address bit zero high means read
// - Pointer holds last address plus one
// - Array reads wrap from top to address zero
// - Current read returns byte at pointer
// - Acknowledged read byte advances to next
// - Lock probe: ID page data byte acknowledged only while unlocked
// - Serial area needs prefix 10, else undefined
// - Serial reads wrap after sixteen bytes
// - Device address: type, chip select, direction
// - Stop after write starts timed programming
// - Write control high blocks array programming
`timescale 1ns/10ps
`default_nettype none
module sece_engine
	import sece_pkg::*;
#(
	parameter int             WR_CYCLES  = WR_CYCLES_DEF,
	parameter logic [127:0]   SERIAL_NUM = SERIAL_DEF
) (
	input  wire logic       sys_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       write_control_input_i,
	input  wire logic       chip_select_bit_high_i,
	input  wire logic       chip_select_bit_mid_i,
	input  wire logic       chip_select_bit_low_i,
	output var  logic       sda_o,
	output var  logic       sda_oe_o,
	output var  logic       busy_o,
	output var  logic       id_locked_o
);
	localparam int TW = $clog2(WR_CYCLES + 1);
	localparam logic [TW-1:0] TMR_LAST = TW'(WR_CYCLES - 1);

	// Refuse a write cycle length that the timer cannot count
	if (WR_CYCLES < 1) begin : g_bad_cycles
		$error("WR_CYCLES must be at least one");
	end

	typedef struct packed {
		sece_state_t                       st;
		logic [3:0]                        cnt;
		logic [7:0]                        sh;
		logic                              rd;
		logic                              xtra;
		logic                              mack;
		logic                              sda_oe;
		logic [7:0]                        ptr;
		logic [7:0]                        wa;
		logic [PAGE_BYTES-1:0][7:0]        pbuf;
		logic [PAGE_BYTES-1:0]             pmask;
		logic                              lock_req;
		logic                              lock;
		logic                              busy;
		logic [TW-1:0]                     tmr;
		logic [MEM_BYTES-1:0][7:0]         mem;
		logic [PAGE_BYTES-1:0][7:0]        idm;
	} sece_core_t;

	sece_core_t s_r;
	sece_core_t s_nxt;
	logic [7:0] cur_byte;
	logic       wbyte;
	logic       dev_match;
	logic       id_blocked;

	sece_line_if line ();

	sece_line_cond u_cond (
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.wc_i      (write_control_input_i),
		.cs_i      ({chip_select_bit_high_i, chip_select_bit_mid_i, chip_select_bit_low_i}),
		.line      (line.src)
	);

	function automatic logic [7:0] sece_inc(input logic [7:0] p, input logic x);
		// Extra areas wrap inside their sixteen bytes, the array wraps at its top
		return x ? {p[7:4], p[3:0] + 4'h1} : p + 8'h1;
	endfunction

	always_comb begin
		cur_byte = UNDEF_BYTE;
		if (!s_r.xtra) begin
			cur_byte = s_r.mem[s_r.ptr];
		end else if (s_r.ptr[7:6] == AREA_ID) begin
			cur_byte = s_r.idm[s_r.ptr[3:0]];
		end else if (s_r.ptr[7:6] == AREA_SN) begin
			cur_byte = SERIAL_NUM[8*(15-int'(s_r.ptr[3:0])) +: 8];
		end
	end

	assign dev_match  = (s_r.sh[7:5] == TYPE_HI) && (s_r.sh[3:1] == line.cs);
	assign id_blocked = s_r.xtra && !s_r.wa[LOCK_SEL_BIT] && s_r.lock;
	assign wbyte      = s_r.st == S_WD && line.scl_fall && !line.start && !line.stop
		&& s_r.cnt == BITS_PER_BYTE && !id_blocked && !(s_r.xtra && s_r.wa[LOCK_SEL_BIT]);

	always_comb begin
		s_nxt = s_r;
		if (s_r.busy) begin
			if (s_r.tmr == TMR_LAST) begin
				s_nxt.busy = 1'b0;
				s_nxt.tmr  = '0;
			end else begin
				s_nxt.tmr = s_r.tmr + 1'b1;
			end
		end
		if (line.start) begin
			s_nxt.st     = S_DEV;
			s_nxt.cnt    = 4'h0;
			s_nxt.sda_oe = 1'b0;
		end else if (line.stop) begin
			s_nxt.st     = S_IDLE;
			s_nxt.sda_oe = 1'b0;
			if (!s_r.busy && !s_r.rd && (s_r.st == S_WD || s_r.st == S_WD_ACK)) begin
				if (s_r.xtra && s_r.wa[LOCK_SEL_BIT]) begin
					if (s_r.lock_req) begin
						s_nxt.lock = 1'b1;
						s_nxt.busy = 1'b1;
					end
				end else if (s_r.xtra) begin
					if (s_r.wa[7:6] == AREA_ID && !s_r.lock && |s_r.pmask) begin
						for (int i = 0; i < PAGE_BYTES; i++) begin
							if (s_r.pmask[i]) begin
								s_nxt.idm[i] = s_r.pbuf[i];
							end
						end
						s_nxt.busy = 1'b1;
					end
				end else if (!line.wc && |s_r.pmask) begin
					for (int i = 0; i < PAGE_BYTES; i++) begin
						if (s_r.pmask[i]) begin
							s_nxt.mem[{s_r.wa[7:4], 4'(i)}] = s_r.pbuf[i];
						end
					end
					s_nxt.busy = 1'b1;
				end
			end
		end else if (line.scl_rise) begin
			case (s_r.st)
				S_DEV, S_WA, S_WD: begin
					s_nxt.sh  = {s_r.sh[6:0], line.sda};
					s_nxt.cnt = s_r.cnt + 4'h1;
				end
				S_RD_ACK: s_nxt.mack = ~line.sda;
				default: ;
			endcase
		end else if (line.scl_fall) begin
			case (s_r.st)
				S_DEV: begin
					if (s_r.cnt == BITS_PER_BYTE) begin
						s_nxt.xtra   = s_r.sh[TYPE_SEL_BIT];
						s_nxt.rd     = s_r.sh[RW_BIT];
						s_nxt.sda_oe = dev_match && !s_r.busy;
						s_nxt.st     = (dev_match && !s_r.busy) ? S_DEV_ACK : S_IDLE;
						if (!s_r.sh[RW_BIT]) begin
							s_nxt.pmask    = '0;
							s_nxt.lock_req = 1'b0;
						end
					end
				end
				S_DEV_ACK: begin
					if (s_r.rd) begin
						s_nxt.st     = S_RD;
						s_nxt.sh     = cur_byte;
						s_nxt.sda_oe = ~cur_byte[7];
						s_nxt.cnt    = 4'h1;
					end else begin
						s_nxt.st     = S_WA;
						s_nxt.sda_oe = 1'b0;
						s_nxt.cnt    = 4'h0;
					end
				end
				S_WA: begin
					if (s_r.cnt == BITS_PER_BYTE) begin
						s_nxt.wa     = s_r.sh;
						s_nxt.ptr    = s_r.sh;
						s_nxt.st     = S_WA_ACK;
						s_nxt.sda_oe = 1'b1;
					end
				end
				S_WA_ACK, S_WD_ACK: begin
					s_nxt.st     = S_WD;
					s_nxt.sda_oe = 1'b0;
					s_nxt.cnt    = 4'h0;
				end
				S_WD: begin
					if (s_r.cnt == BITS_PER_BYTE) begin
						s_nxt.st     = S_WD_ACK;
						s_nxt.sda_oe = !id_blocked;
						if (s_r.xtra && s_r.wa[LOCK_SEL_BIT]) begin
							if (!s_r.lock_req) begin
								s_nxt.lock_req = s_r.sh[LOCK_DATA_BIT];
							end
						end else if (!id_blocked) begin
							s_nxt.pbuf[s_r.ptr[3:0]]  = s_r.sh;
							s_nxt.pmask[s_r.ptr[3:0]] = 1'b1;
							s_nxt.ptr = {s_r.ptr[7:4], s_r.ptr[3:0] + 4'h1};
						end
					end
				end
				S_RD: begin
					if (s_r.cnt == BITS_PER_BYTE) begin
						s_nxt.st     = S_RD_ACK;
						s_nxt.sda_oe = 1'b0;
						s_nxt.ptr    = sece_inc(s_r.ptr, s_r.xtra);
					end else begin
						s_nxt.sh     = {s_r.sh[6:0], 1'b0};
						s_nxt.sda_oe = ~s_r.sh[6];
						s_nxt.cnt    = s_r.cnt + 4'h1;
					end
				end
				S_RD_ACK: begin
					if (s_r.mack) begin
						s_nxt.st     = S_RD;
						s_nxt.sh     = cur_byte;
						s_nxt.sda_oe = ~cur_byte[7];
						s_nxt.cnt    = 4'h1;
					end else begin
						s_nxt.st = S_IDLE;
					end
				end
				default: s_nxt.st = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_r    <= '0;
			s_r.st <= S_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sda_o       = 1'b0;
	assign sda_oe_o    = s_r.sda_oe;
	assign busy_o      = s_r.busy;
	assign id_locked_o = s_r.lock;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_quiet_fall;
		line.scl_fall && !line.start && !line.stop;
	endsequence
	sequence s_wd_end;
		s_r.st == S_WD && s_r.cnt == BITS_PER_BYTE ##0 s_quiet_fall;
	endsequence
	sequence s_rd_end;
		s_r.st == S_RD && s_r.cnt == BITS_PER_BYTE ##0 s_quiet_fall;
	endsequence

	a_busy_addr_nack: assert property (s_r.st == S_DEV && s_r.cnt == BITS_PER_BYTE && s_r.busy ##0 s_quiet_fall
		|=> !s_r.sda_oe && s_r.st == S_IDLE) else $error("address acknowledged during write cycle");
	a_dev_addr_ack: assert property (s_r.st == S_DEV && s_r.cnt == BITS_PER_BYTE && !s_r.busy && dev_match
		##0 s_quiet_fall |=> s_r.sda_oe && s_r.st == S_DEV_ACK) else $error("matching address not acknowledged");
	a_read_first: assert property (s_r.st == S_DEV_ACK && s_r.rd ##0 s_quiet_fall
		|=> s_r.st == S_RD && s_r.sh == $past(cur_byte) && s_r.sda_oe == ~s_r.sh[7]) else $error("wrong first read byte");
	a_page_wrap: assert property (wbyte |=> s_r.ptr[7:4] == $past(s_r.ptr[7:4])
		&& s_r.ptr[3:0] == $past(s_r.ptr[3:0]) + 4'h1) else $error("page write address left its page");
	a_page_ack: assert property (s_wd_end ##0 !id_blocked |=> s_r.sda_oe [*1] ##1 1'b1)
		else $error("page write byte not acknowledged");
	a_locked_nack: assert property (s_wd_end ##0 id_blocked |=> !s_r.sda_oe && s_r.pmask == $past(s_r.pmask))
		else $error("locked ID page byte acknowledged");
	a_lock_sticky: assert property ($changed(s_r.lock) |-> s_r.lock && $past(line.stop && s_r.lock_req))
		else $error("ID page lock changed outside a lock command");
	a_wc_block: assert property (line.stop && line.wc && !s_r.xtra |=> s_r.mem == $past(s_r.mem))
		else $error("array programmed with write control high");
	a_busy_len: assert property ($fell(s_r.busy) |-> $past(s_r.tmr) == TMR_LAST)
		else $error("write cycle length wrong");
	a_read_wrap: assert property (s_rd_end ##0 !s_r.xtra |=> s_r.ptr == $past(s_r.ptr) + 8'h1)
		else $error("array read pointer did not advance");
	a_sn_wrap: assert property (s_rd_end ##0 s_r.xtra |=> s_r.ptr[7:4] == $past(s_r.ptr[7:4])
		&& s_r.ptr[3:0] == $past(s_r.ptr[3:0]) + 4'h1) else $error("serial read left its block");
endmodule // sece_engine
`default_nettype wire

// ==== rtl/sece_pkg.sv ====
// Shared constants and types of the serial EEPROM command engine
package sece_pkg;
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          T_WR_NS       = 5000000;
	localparam int          WR_CYCLES_DEF = T_WR_NS / CLK_PERIOD_NS;
	localparam logic [2:0]  TYPE_HI       = 3'h5;
	localparam int          TYPE_SEL_BIT  = 4;
	localparam int          RW_BIT        = 0;
	localparam logic [1:0]  AREA_ID       = 2'h0;
	localparam logic [1:0]  AREA_SN       = 2'h2;
	localparam int          LOCK_SEL_BIT  = 6;
	localparam int          LOCK_DATA_BIT = 1;
	localparam int          PAGE_BYTES    = 16;
	localparam int          MEM_BYTES     = 256;
	localparam logic [7:0]  UNDEF_BYTE    = 8'hff;
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	localparam logic [127:0] SERIAL_DEF   = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

	typedef enum logic [8:0] {
		S_IDLE    = 9'h001,
		S_DEV     = 9'h002,
		S_DEV_ACK = 9'h004,
		S_WA      = 9'h008,
		S_WA_ACK  = 9'h010,
		S_WD      = 9'h020,
		S_WD_ACK  = 9'h040,
		S_RD      = 9'h080,
		S_RD_ACK  = 9'h100
	} sece_state_t;
endpackage

// ==== rtl/sece_line_if.sv ====
// Conditioned bus events passed from the line conditioner to the engine
`timescale 1ns/10ps
`default_nettype none
interface sece_line_if;
	logic       scl_rise;
	logic       scl_fall;
	logic       start;
	logic       stop;
	logic       sda;
	logic       wc;
	logic [2:0] cs;
	modport src (output scl_rise, scl_fall, start, stop, sda, wc, cs);
	modport dst (input scl_rise, scl_fall, start, stop, sda, wc, cs);
endinterface
`default_nettype wire

// ==== rtl/sece_line_cond.sv ====
// Pin synchronisers and start, stop and clock edge detection
`timescale 1ns/10ps
`default_nettype none
module sece_line_cond
	import sece_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       wc_i,
	input  wire logic [2:0] cs_i,
	sece_line_if.src        line
);
	typedef struct packed {
		logic       scl_a;
		logic       scl_b;
		logic       scl_c;
		logic       sda_a;
		logic       sda_b;
		logic       sda_c;
		logic       wc_a;
		logic       wc_b;
		logic [2:0] cs_a;
		logic [2:0] cs_b;
	} sece_sync_t;

	sece_sync_t r_r;
	sece_sync_t r_nxt;

	always_comb begin
		r_nxt       = r_r;
		r_nxt.scl_a = scl_i;
		r_nxt.scl_b = r_r.scl_a;
		r_nxt.scl_c = r_r.scl_b;
		r_nxt.sda_a = sda_i;
		r_nxt.sda_b = r_r.sda_a;
		r_nxt.sda_c = r_r.sda_b;
		r_nxt.wc_a  = wc_i;
		r_nxt.wc_b  = r_r.wc_a;
		r_nxt.cs_a  = cs_i;
		r_nxt.cs_b  = r_r.cs_a;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			r_r <= '{scl_a: 1'b1, scl_b: 1'b1, scl_c: 1'b1, sda_a: 1'b1, sda_b: 1'b1, sda_c: 1'b1,
				wc_a: 1'b1, wc_b: 1'b1, cs_a: 3'h0, cs_b: 3'h0};
		end else begin
			r_r <= r_nxt;
		end
	end

	assign line.scl_rise = r_r.scl_b & ~r_r.scl_c;
	assign line.scl_fall = ~r_r.scl_b & r_r.scl_c;
	assign line.start    = r_r.scl_b & r_r.scl_c & r_r.sda_c & ~r_r.sda_b;
	assign line.stop     = r_r.scl_b & r_r.scl_c & ~r_r.sda_c & r_r.sda_b;
	assign line.sda      = r_r.sda_b;
	assign line.wc       = r_r.wc_b;
	assign line.cs       = r_r.cs_b;
endmodule // sece_line_cond
`default_nettype wire

// ==== test/sece_mst.sv ====
// Behavioural two-wire bus master that clocks the bus and pulls the data line low
`timescale 1ns/10ps
`default_nettype none
module sece_mst (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// Clock low first so a repeated start never looks like a stop
	task automatic start();
		scl_o = 1'b0;
		tick(2);
		sda_low_o = 1'b0;
		tick(2);
		scl_o = 1'b1;
		tick(4);
		sda_low_o = 1'b1;
		tick(4);
	endtask

	// Clock stays high afterwards: idle bus
	task automatic stop();
		scl_o = 1'b0;
		tick(2);
		sda_low_o = 1'b1;
		tick(2);
		scl_o = 1'b1;
		tick(4);
		sda_low_o = 1'b0;
		tick(4);
	endtask

	// Data changes only while the clock is low; line sampled at end of high phase
	task automatic bitx(input logic b, output logic r);
		scl_o = 1'b0;
		tick(1);
		sda_low_o = !b;
		tick(3);
		scl_o = 1'b1;
		tick(4);
		r = sda_i;
	endtask

	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(b[i], r);
		bitx(1'b1, ack);
	endtask

	task automatic rbyte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
		bitx(last, r);
	endtask
endmodule // sece_mst
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking testbench of the serial EEPROM command engine
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sece_pkg::*;
	localparam logic [127:0] SN = 128'h3c5a_9617_e2d4_08bf_71a6_c359_4e20_8dd1;
	logic       sys_clk_i = 1'b0;
	logic       arst_n_i  = 1'b0;
	logic       wc        = 1'b0;
	logic [2:0] cs        = 3'h0;
	logic       scl;
	logic       sda_low;
	logic       sda_o;
	logic       sda_oe;
	logic       busy;
	logic       lockd;
	wire logic  sda_w = !(sda_low || (sda_oe && !sda_o));
	logic [7:0] mem [256];
	logic [7:0] idp [16];
	logic       lk = 1'b0;
	logic [7:0] ptr = 8'h00;
	int         seed = 36;
	int         failures = 0;
	int         check_count = 0;

	sece_mst mst (.clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));

	sece_engine #(.WR_CYCLES(200), .SERIAL_NUM(SN)) uut (
		.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_w),
		.write_control_input_i(wc), .chip_select_bit_high_i(cs[2]),
		.chip_select_bit_mid_i(cs[1]), .chip_select_bit_low_i(cs[0]),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .busy_o(busy), .id_locked_o(lockd));

	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	task automatic end_sim();
		if (failures == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	function automatic logic [7:0] dv(input logic t, input logic rw);
		return {TYPE_HI, t, cs, rw};
	endfunction

	function automatic logic [7:0] expv(input logic t, input logic [7:0] a);
		if (!t) return mem[a];
		if (a[7:6] == AREA_ID) return idp[a[3:0]];
		if (a[7:6] == AREA_SN) return SN[127 - 8 * a[3:0] -: 8];
		return UNDEF_BYTE;
	endfunction

	task automatic send(input logic [7:0] b, input logic ea);
		logic a;
		mst.wbyte(b, a);
		chk(a, ea);
	endtask

	task automatic rd(input logic t, input logic [7:0] wa, input int n, input logic cur);
		logic [7:0] b;
		if (!cur) begin
			mst.start();
			send(dv(t, 1'b0), 1'b0);
			send(wa, 1'b0);
			ptr = wa;
		end
		mst.start();
		send(dv(t, 1'b1), 1'b0);
		for (int i = 0; i < n; i++) begin
			mst.rbyte(i == n - 1, b);
			chk(b, expv(t, ptr));
			ptr = t ? {ptr[7:4], 4'(ptr[3:0] + 4'h1)} : 8'(ptr + 8'h1);
		end
		mst.stop();
	endtask

	task automatic wr(input logic t, input logic [7:0] wa, input int n, input logic [7:0] d0);
		logic [7:0] d;
		logic       bz;
		logic       lkn;
		logic [3:0] o;
		bz = 1'b0;
		lkn = 1'b0;
		mst.start();
		send(dv(t, 1'b0), 1'b0);
		send(wa, 1'b0);
		for (int i = 0; i < n; i++) begin
			d = (i == 0) ? d0 : 8'($random(seed));
			o = 4'(wa[3:0] + 4'(i));
			send(d, t && !wa[6] && lk);
			if (!t) begin
				if (!wc) mem[{wa[7:4], o}] = d;
				bz = bz | !wc;
			end else if (wa[LOCK_SEL_BIT]) begin
				if (d[LOCK_DATA_BIT]) lkn = 1'b1;
				bz = bz | lkn;
			end else if (wa[7:6] == AREA_ID && !lk) begin
				idp[o] = d;
				bz = 1'b1;
			end
		end
		mst.stop();
		lk = lk | lkn;
		tick(5);
		chk(busy, bz);
		if (bz) begin
			mst.start();
			send(dv(t, 1'b0), 1'b1);
			mst.stop();
			for (int k = 0; k < 600 && busy !== 1'b0; k++) tick(1);
			if (busy !== 1'b0) begin
				failures++;
				end_sim();
			end
		end
		mst.start();
		send(dv(t, 1'b0), 1'b0);
		mst.stop();
		chk(lockd, lk);
	endtask

	initial begin
		logic a;
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
		for (int i = 0; i < 16; i++) idp[i] = 8'h00;
		cs = 3'($random(seed));
		tick(20);
		arst_n_i = 1'b1;
		tick(5);
		wr(1'b0, 8'h3e, 18, 8'h5a);
		rd(1'b0, 8'h30, 16, 1'b0);
		rd(1'b0, 8'h00, 2, 1'b1);
		rd(1'b0, 8'hfe, 4, 1'b0);
		wc = 1'b1;
		wr(1'b0, 8'h31, 3, 8'h11);
		wc = 1'b0;
		rd(1'b0, 8'h30, 4, 1'b0);
		wr(1'b1, 8'h0e, 4, 8'ha5);
		rd(1'b1, 8'h0e, 2, 1'b0);
		rd(1'b1, 8'h80, 18, 1'b0);
		rd(1'b1, 8'hc3, 2, 1'b0);
		wr(1'b1, 8'h05, 1, 8'h3c);
		wr(1'b1, 8'h40, 1, 8'hfd);
		wr(1'b1, 8'h40, 1, 8'h02);
		wr(1'b1, 8'h05, 1, 8'hc3);
		rd(1'b1, 8'h00, 16, 1'b0);
		mst.start();
		mst.wbyte({TYPE_HI, 1'b0, ~cs, 1'b0}, a);
		chk(a, 1'b1);
		mst.stop();
		end_sim();
	end
endmodule // tb
`default_nettype wire
